/* File: logic/moc_defines.vh */
/*
  option loader constants: apb offsets, field positions, reset values,
  range codes and timing counts.
  assumes a 200 MHz pclk and a 32-bit apb bus.
*/
`ifndef MOC_DEFINES_VH
`define MOC_DEFINES_VH

// apb register byte offsets
`define MOC_OFF_OPTS      8'h00
`define MOC_OFF_CTRL      8'h04
`define MOC_OFF_IRQ_STAT  8'h08
`define MOC_OFF_IRQ_MASK  8'h0c
`define MOC_OFF_MEAS      8'h10

// option status fields
`define MOC_OPT_MAP_A     0
`define MOC_OPT_MAP_B     1
`define MOC_OPT_MON_EN    2
`define MOC_OPT_RANGE_LO  3
`define MOC_OPT_RANGE_HI  4
`define MOC_OPT_PLL_EN    5
`define MOC_OPT_RST_LONG  6
`define MOC_OPT_WATCHDOG_HALT_RESET_OPT  7
`define MOC_OPT_WDG_HW    8
`define MOC_OPT_SAFE_CLK  9
`define MOC_OPT_PLL_OK    10
`define MOC_OPT_CPU_HOLD  11
`define MOC_OPT_WDG_EN    12

// control fields and reset value
`define MOC_CTRL_WDG_SOFT 0
`define MOC_CTRL_RST      1'b0

// interrupt status and mask bits
`define MOC_IRQ_W         4
`define MOC_IRQ_CLK_FAIL  0
`define MOC_IRQ_PLL_BAD   1
`define MOC_IRQ_HALT_RST  2
`define MOC_IRQ_DLY_DONE  3
`define MOC_MASK_RST      4'h0

// monitor range codes
`define MOC_RANGE_HIGH    2'h0
`define MOC_RANGE_MEDIUM  2'h1
`define MOC_RANGE_MED_LOW 2'h2
`define MOC_RANGE_LOW     2'h3

// range bounds in MHz, equal to ticks per 1 us window
`define MOC_HIGH_LO       6'd8
`define MOC_HIGH_HI       6'd16
`define MOC_MED_LO        6'd4
`define MOC_MED_HI        6'd8
`define MOC_MLOW_LO       6'd2
`define MOC_MLOW_HI       6'd4
`define MOC_LOW_LO        6'd1
`define MOC_LOW_HI        6'd2
`define MOC_PLL_LO        6'd2
`define MOC_PLL_HI        6'd4

// timing
`define MOC_CLK_NS        5
`define MOC_WIN_NS        1000
`define MOC_WIN_CYC       (`MOC_WIN_NS / `MOC_CLK_NS)
`define MOC_WIN_LAST      8'd199
`define MOC_DLY_LONG      13'd4096
`define MOC_DLY_SHORT     13'd256

`endif

/* File: logic/moc_clk_monitor.v */
/*
  clock monitor: counts oscillator ticks over a 1 us window and checks
  the count against the selected range and the pll input range.
  assumes osc_tick is a one-cycle pulse per oscillator period,
  synchronous to pclk.
*/
`timescale 1ns/100ps
`include "moc_defines.vh"

module moc_clk_monitor (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       osc_tick,
  input  wire       armed,
  input  wire       mon_en,
  input  wire [1:0] range_code,
  output reg  [5:0] meas_r,
  output reg        fail_r,
  output reg        pll_ok_r,
  output reg        win_done_r
);

  reg  [7:0] win_r;
  reg  [5:0] cnt_r;
  wire [5:0] cnt_fin;
  wire       win_end;
  reg  [5:0] lo;
  reg  [5:0] hi;

  function in_range;
    input [5:0] val;
    input [5:0] lo_b;
    input [5:0] hi_b;
    begin
      in_range = (val >= lo_b) && (val <= hi_b);
    end
  endfunction

  // range bounds per code
  always @* begin
    case (range_code)
      `MOC_RANGE_HIGH:    begin lo = `MOC_HIGH_LO; hi = `MOC_HIGH_HI; end
      `MOC_RANGE_MEDIUM:  begin lo = `MOC_MED_LO;  hi = `MOC_MED_HI;  end
      `MOC_RANGE_MED_LOW: begin lo = `MOC_MLOW_LO; hi = `MOC_MLOW_HI; end
      default:            begin lo = `MOC_LOW_LO;  hi = `MOC_LOW_HI;  end
    endcase
  end

  assign win_end = (win_r == `MOC_WIN_LAST);
  assign cnt_fin = (cnt_r == 6'h3f) ? cnt_r : cnt_r + {5'h00, osc_tick};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r      <= 8'h00;
      cnt_r      <= 6'h00;
      meas_r     <= 6'h00;
      fail_r     <= 1'b0;
      pll_ok_r   <= 1'b0;
      win_done_r <= 1'b0;
    end else begin
      win_done_r <= win_end;
      if (win_end) begin
        win_r    <= 8'h00;
        cnt_r    <= 6'h00;
        meas_r   <= cnt_fin;
        pll_ok_r <= in_range(cnt_fin, `MOC_PLL_LO, `MOC_PLL_HI);
        if (armed && mon_en && !in_range(cnt_fin, lo, hi)) begin
          fail_r <= 1'b1;
        end
      end else begin
        win_r <= win_r + 8'h01;
        cnt_r <= cnt_fin;
      end
    end
  end

endmodule // moc_clk_monitor

/* File: logic/moc_delay_cnt.v */
/*
  cpu-cycle delay counter for the reset phase and halt exit.
  assumes cpu_tick is a one-cycle pulse per cpu cycle, synchronous to pclk.
*/
`timescale 1ns/100ps
`include "moc_defines.vh"

module moc_delay_cnt (
  input  wire pclk,
  input  wire presetn,
  input  wire start,
  input  wire long_sel,
  input  wire cpu_tick,
  output reg  busy_r,
  output reg  done_r
);

  reg [12:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 13'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r  <= long_sel ? `MOC_DLY_LONG : `MOC_DLY_SHORT;
        busy_r <= 1'b1;
      end else if (busy_r && cpu_tick) begin
        cnt_r <= cnt_r - 13'h0001;
        if (cnt_r == 13'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

endmodule // moc_delay_cnt

/* File: logic/moc_top.v */
/*
  option loader: latches the configuration options at reset release and
  applies them to pin mapping, clock monitor, pll, reset delay and
  watchdog; apb slave with status, control and interrupt registers.
  assumes all inputs synchronous to pclk and options stable at reset.
*/
`timescale 1ns/100ps
`include "moc_defines.vh"

// Overview of operation
// - capture input two comes from pc1 or pd1 per mapping option a.
// - mapping b lin-on gives pd3..pd5 to lin, timer to pb6, pb7, pc0.
// - mapping b alternative disables lin and puts timer on pd3..pd5.
// - monitor enabled: out-of-range clock switches source to safe oscillator.
// - four range codes: 16..8, 8..4, 4..2, 2..1 MHz.
// - pll option doubles input clock; valid only for 2..4 MHz input.
// - reset phase and halt exit last 4096 or 256 cpu cycles.
// - watchdog on and halt-reset option set: halt causes chip reset.
// - watchdog enable source chosen by option: software or hardware.
module moc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cfg_alt_pin_map_sel_a,
  input  wire        cfg_alt_pin_map_sel_b,
  input  wire        cfg_clock_monitor_enable,
  input  wire [1:0]  cfg_monitor_freq_range,
  input  wire        cfg_pll_enable,
  input  wire        cfg_reset_delay_select,
  input  wire        cfg_watchdog_halt_reset_opt,
  input  wire        cfg_watchdog_enable_source,
  input  wire        osc_tick,
  input  wire        cpu_tick,
  input  wire        halt_exec,
  input  wire        halt_exit,
  input  wire        pin_pc1_in,
  input  wire        pin_pd1_in,
  input  wire [2:0]  pin_pd345_in,
  input  wire [2:0]  pin_pbc_in,
  input  wire [2:0]  timer_out,
  input  wire [2:0]  lin_out,
  output reg         timer_capture_in_two,
  output reg  [2:0]  timer_in,
  output reg  [2:0]  lin_in,
  output reg  [2:0]  pin_pd345_out,
  output reg  [2:0]  pin_pbc_out,
  output reg         lin_serial_unit_en,
  output reg         clk_src_safe,
  output reg         pll_enable,
  output reg         pll_in_range,
  output reg         cpu_hold,
  output reg         chip_reset_req,
  output reg         watchdog_en,
  output reg         irq
);

  // latched options
  reg        loaded_r;
  reg        alt_pin_map_sel_a_r;
  reg        alt_pin_map_sel_b_r;
  reg        clock_monitor_enable_r;
  reg  [1:0] monitor_freq_range_r;
  reg        pll_opt_r;
  reg        reset_delay_select_r;
  reg        watchdog_halt_reset_opt_r;
  reg        watchdog_enable_source_r;

  // software registers
  reg                  ctrl_wdg_soft_r;
  reg  [`MOC_IRQ_W-1:0] irq_stat_r;
  reg  [`MOC_IRQ_W-1:0] irq_mask_r;
  reg  [`MOC_IRQ_W-1:0] irq_stat_nxt;
  reg  [`MOC_IRQ_W-1:0] events;
  reg                  fail_d_r;
  reg                  ctrl_wdg_soft_nxt;
  reg  [`MOC_IRQ_W-1:0] irq_mask_nxt;

  // apb decode
  reg  [31:0] rdata_nxt;
  reg         err_nxt;
  reg  [31:0] prdata_nxt;
  reg         pready_nxt;
  reg         pslverr_nxt;
  wire        setup_ph;
  wire        wr_take;
  wire        dly_start;
  wire        wdg_en_nxt;
  wire        dly_long_sel;

  // submodule outputs
  wire [5:0]  meas;
  wire        mon_fail;
  wire        pll_ok;
  wire        win_done;
  wire        dly_busy;
  wire        dly_done;

  // write strobe for one register offset
  function reg_hit;
    input       take;
    input [7:0] addr;
    input [7:0] off;
    begin
      reg_hit = take && (addr == off);
    end
  endfunction

  // halt instruction that must end in a chip reset
  function halt_rst;
    input exec;
    input wdg_on;
    input opt;
    begin
      halt_rst = exec && wdg_on && opt;
    end
  endfunction

  assign setup_ph  = psel && !penable;
  assign wr_take   = psel && penable && pready && pwrite;
  assign dly_start = !loaded_r || halt_exit;

  // delay length: live option before the latch, latched value after it
  assign dly_long_sel = loaded_r ? reset_delay_select_r : cfg_reset_delay_select;

  // watchdog enable source
  assign wdg_en_nxt = watchdog_enable_source_r ? 1'b1 : ctrl_wdg_soft_r;

  // option latch, taken once at the first edge after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r                  <= 1'b0;
      alt_pin_map_sel_a_r       <= 1'b0;
      alt_pin_map_sel_b_r       <= 1'b0;
      clock_monitor_enable_r    <= 1'b0;
      monitor_freq_range_r      <= `MOC_RANGE_HIGH;
      pll_opt_r                 <= 1'b0;
      reset_delay_select_r      <= 1'b0;
      watchdog_halt_reset_opt_r <= 1'b0;
      watchdog_enable_source_r  <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r                  <= 1'b1;
      alt_pin_map_sel_a_r       <= cfg_alt_pin_map_sel_a;
      alt_pin_map_sel_b_r       <= cfg_alt_pin_map_sel_b;
      clock_monitor_enable_r    <= cfg_clock_monitor_enable;
      monitor_freq_range_r      <= cfg_monitor_freq_range;
      pll_opt_r                 <= cfg_pll_enable;
      reset_delay_select_r      <= cfg_reset_delay_select;
      watchdog_halt_reset_opt_r <= cfg_watchdog_halt_reset_opt;
      watchdog_enable_source_r  <= cfg_watchdog_enable_source;
    end
  end

  moc_clk_monitor u_mon (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_tick   (osc_tick),
    .armed      (loaded_r),
    .mon_en     (clock_monitor_enable_r),
    .range_code (monitor_freq_range_r),
    .meas_r     (meas),
    .fail_r     (mon_fail),
    .pll_ok_r   (pll_ok),
    .win_done_r (win_done)
  );

  moc_delay_cnt u_dly (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (dly_start),
    .long_sel (dly_long_sel),
    .cpu_tick (cpu_tick),
    .busy_r   (dly_busy),
    .done_r   (dly_done)
  );

  // pin routing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_capture_in_two <= 1'b0;
      timer_in             <= 3'h0;
      lin_in               <= 3'h7;
      pin_pd345_out        <= 3'h0;
      pin_pbc_out          <= 3'h0;
      lin_serial_unit_en   <= 1'b0;
    end else if (!loaded_r) begin
      timer_capture_in_two <= 1'b0;
      timer_in             <= 3'h0;
      lin_in               <= 3'h7;
      pin_pd345_out        <= 3'h0;
      pin_pbc_out          <= 3'h0;
      lin_serial_unit_en   <= 1'b0;
    end else begin
      timer_capture_in_two <= alt_pin_map_sel_a_r ? pin_pd1_in : pin_pc1_in;
      if (alt_pin_map_sel_b_r) begin
        lin_serial_unit_en <= 1'b0;
        pin_pd345_out      <= timer_out;
        timer_in           <= pin_pd345_in;
        pin_pbc_out        <= 3'h0;
        lin_in             <= 3'h7;
      end else begin
        lin_serial_unit_en <= loaded_r;
        pin_pd345_out      <= lin_out;
        lin_in             <= pin_pd345_in;
        pin_pbc_out        <= timer_out;
        timer_in           <= pin_pbc_in;
      end
    end
  end

  // clock, pll, delay and watchdog outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_safe   <= 1'b0;
      pll_enable     <= 1'b0;
      pll_in_range   <= 1'b0;
      cpu_hold       <= 1'b1;
      chip_reset_req <= 1'b0;
      watchdog_en    <= 1'b0;
      fail_d_r       <= 1'b0;
    end else begin
      clk_src_safe   <= mon_fail;
      pll_enable     <= pll_opt_r;
      pll_in_range   <= pll_ok;
      cpu_hold       <= dly_start || dly_busy;
      chip_reset_req <= halt_rst(halt_exec, watchdog_en, watchdog_halt_reset_opt_r);
      watchdog_en    <= wdg_en_nxt;
      fail_d_r       <= mon_fail;
    end
  end

  // interrupt events
  always @* begin
    events                    = {`MOC_IRQ_W{1'b0}};
    events[`MOC_IRQ_CLK_FAIL] = mon_fail && !fail_d_r;
    events[`MOC_IRQ_PLL_BAD]  = win_done && pll_opt_r && !pll_ok;
    events[`MOC_IRQ_HALT_RST] = halt_rst(halt_exec, watchdog_en, watchdog_halt_reset_opt_r);
    events[`MOC_IRQ_DLY_DONE] = dly_done;
  end

  // write-one-to-clear, a new event wins over the clear
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (reg_hit(wr_take, paddr, `MOC_OFF_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~pwdata[`MOC_IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  // read mux and error decode
  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    case (paddr)
      `MOC_OFF_OPTS: begin
        rdata_nxt[`MOC_OPT_MAP_A]    = alt_pin_map_sel_a_r;
        rdata_nxt[`MOC_OPT_MAP_B]    = alt_pin_map_sel_b_r;
        rdata_nxt[`MOC_OPT_MON_EN]   = clock_monitor_enable_r;
        rdata_nxt[`MOC_OPT_RANGE_LO] = monitor_freq_range_r[0];
        rdata_nxt[`MOC_OPT_RANGE_HI] = monitor_freq_range_r[1];
        rdata_nxt[`MOC_OPT_PLL_EN]   = pll_opt_r;
        rdata_nxt[`MOC_OPT_RST_LONG] = reset_delay_select_r;
        rdata_nxt[`MOC_OPT_WATCHDOG_HALT_RESET_OPT] = watchdog_halt_reset_opt_r;
        rdata_nxt[`MOC_OPT_WDG_HW]   = watchdog_enable_source_r;
        rdata_nxt[`MOC_OPT_SAFE_CLK] = clk_src_safe;
        rdata_nxt[`MOC_OPT_PLL_OK]   = pll_in_range;
        rdata_nxt[`MOC_OPT_CPU_HOLD] = cpu_hold;
        rdata_nxt[`MOC_OPT_WDG_EN]   = watchdog_en;
      end
      `MOC_OFF_CTRL: begin
        rdata_nxt[`MOC_CTRL_WDG_SOFT] = ctrl_wdg_soft_r;
      end
      `MOC_OFF_IRQ_STAT: begin
        rdata_nxt[`MOC_IRQ_W-1:0] = irq_stat_r;
      end
      `MOC_OFF_IRQ_MASK: begin
        rdata_nxt[`MOC_IRQ_W-1:0] = irq_mask_r;
      end
      `MOC_OFF_MEAS: begin
        rdata_nxt[5:0] = meas;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // apb slave: one setup, answer in the first access cycle
  always @* begin
    prdata_nxt  = prdata;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup_ph) begin
      prdata_nxt  = pwrite ? 32'h0000_0000 : rdata_nxt;
      pready_nxt  = 1'b1;
      pslverr_nxt = err_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // software register next values
  always @* begin
    ctrl_wdg_soft_nxt = ctrl_wdg_soft_r;
    irq_mask_nxt      = irq_mask_r;
    if (reg_hit(wr_take, paddr, `MOC_OFF_CTRL)) begin
      ctrl_wdg_soft_nxt = pwdata[`MOC_CTRL_WDG_SOFT];
    end
    if (reg_hit(wr_take, paddr, `MOC_OFF_IRQ_MASK)) begin
      irq_mask_nxt = pwdata[`MOC_IRQ_W-1:0];
    end
  end

  // software registers and interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_wdg_soft_r <= `MOC_CTRL_RST;
      irq_mask_r      <= `MOC_MASK_RST;
      irq_stat_r      <= {`MOC_IRQ_W{1'b0}};
      irq             <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq        <= |(irq_stat_nxt & irq_mask_r);
      ctrl_wdg_soft_r <= ctrl_wdg_soft_nxt;
      irq_mask_r      <= irq_mask_nxt;
    end
  end

endmodule // moc_top

/* File: dv/moc_top_monitor.sv */
/*
  checker for the option loader: pin routing, monitor, watchdog, delay.
  assumes the hold length is counted in cpu_tick pulses.
*/
`timescale 1ns/100ps
module moc_top_monitor (
  input wire       pclk,
  input wire       presetn,
  input wire       cfg_alt_pin_map_sel_a,
  input wire       cfg_alt_pin_map_sel_b,
  input wire       cfg_clock_monitor_enable,
  input wire       cfg_pll_enable,
  input wire       cfg_reset_delay_select,
  input wire       cfg_watchdog_halt_reset_opt,
  input wire       cfg_watchdog_enable_source,
  input wire       halt_exec,
  input wire       halt_exit,
  input wire       cpu_tick,
  input wire       pin_pc1_in,
  input wire       pin_pd1_in,
  input wire [2:0] pin_pd345_in,
  input wire [2:0] pin_pbc_in,
  input wire [2:0] timer_out,
  input wire [2:0] lin_out,
  input wire       timer_capture_in_two,
  input wire [2:0] timer_in,
  input wire [2:0] lin_in,
  input wire [2:0] pin_pd345_out,
  input wire [2:0] pin_pbc_out,
  input wire       lin_serial_unit_en,
  input wire       clk_src_safe,
  input wire       pll_enable,
  input wire       cpu_hold,
  input wire       chip_reset_req,
  input wire       watchdog_en
);
  reg        ld_r;
  reg [6:0]  opt_r;
  reg [12:0] hcnt_r;
  wire [12:0] dly = opt_r[4] ? 13'd4096 : 13'd256;
  // own copy of the options, taken at the first edge after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_r   <= 1'b0;
      opt_r  <= 7'h00;
      hcnt_r <= 13'h0;
    end else begin
      hcnt_r <= cpu_hold ? hcnt_r + {12'h000, cpu_tick} : 13'h0;
      if (!ld_r) begin
        ld_r  <= 1'b1;
        opt_r <= {cfg_watchdog_enable_source, cfg_watchdog_halt_reset_opt,
                  cfg_reset_delay_select, cfg_pll_enable, cfg_clock_monitor_enable,
                  cfg_alt_pin_map_sel_b, cfg_alt_pin_map_sel_a};
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_lin_side;
    lin_in == $past(pin_pd345_in) && pin_pd345_out == $past(lin_out) && lin_serial_unit_en;
  endsequence
  sequence s_tmr_pb;
    timer_in == $past(pin_pbc_in) && pin_pbc_out == $past(timer_out);
  endsequence
  a_cap_route: assert property (ld_r |=> timer_capture_in_two ==
    $past(opt_r[0] ? pin_pd1_in : pin_pc1_in)) else $error("capture pin wrong");
  a_lin_map: assert property (ld_r && !opt_r[1] |=> s_lin_side and s_tmr_pb)
    else $error("lin mapping wrong");
  a_timer_pd: assert property (ld_r && opt_r[1] |=> timer_in == $past(pin_pd345_in) &&
    pin_pd345_out == $past(timer_out) && lin_in == 3'h7 && pin_pbc_out == 3'h0 &&
    !lin_serial_unit_en) else $error("timer mapping wrong");
  a_safe_sticky: assert property (clk_src_safe |=> clk_src_safe)
    else $error("safe clock dropped");
  a_safe_cause: assert property ($rose(clk_src_safe) |-> opt_r[2])
    else $error("safe clock with monitor off");
  a_pll_fixed: assert property (ld_r |=> pll_enable == opt_r[3])
    else $error("pll enable not latched");
  a_wdg_hw: assert property (ld_r && $past(ld_r) && opt_r[6] |-> watchdog_en)
    else $error("hardware watchdog off");
  a_halt_reset: assert property (ld_r |=> chip_reset_req ==
    $past(halt_exec && watchdog_en && opt_r[5])) else $error("halt reset wrong");
  a_exit_hold: assert property (halt_exit |=> cpu_hold)
    else $error("halt exit without hold");
  a_hold_short: assert property ($fell(cpu_hold) |-> $past(hcnt_r) + 13'd2 >= dly)
    else $error("hold too short");
  a_hold_long: assert property (hcnt_r <= dly + 13'd6)
    else $error("hold too long");
endmodule // moc_top_monitor
bind moc_top moc_top_monitor moc_top_monitor_i (.*);

/* File: dv/moc_top_tb.sv */
/*
  testbench for the option loader: four option sets, apb register access.
  assumes cpu_tick every cycle, every other cycle in run 1.
*/
`timescale 1ns/100ps
module moc_top_tb;
  reg         pclk, presetn, psel, penable, pwrite, osc_tick, halt_exec, halt_exit;
  reg         pin_pc1_in, pin_pd1_in, e, cpu_tick, slow;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, q;
  reg  [8:0]  cfg, c;
  reg  [2:0]  pin_pd345_in, pin_pbc_in, timer_out, lin_out;
  reg  [8:0]  tbl [0:3];
  reg  [7:0]  pertbl [0:3];
  wire [31:0] prdata;
  wire        pready, pslverr, cap, lin_en, safe, pll_en, pll_rng, hold, rst_req, wdg_en, irq;
  wire [2:0]  timer_in, lin_in, pd_out, pbc_out;
  integer     n_errors, n_checks, per, tcnt, i, n;
  moc_top moc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_alt_pin_map_sel_a(cfg[0]), .cfg_alt_pin_map_sel_b(cfg[1]),
    .cfg_clock_monitor_enable(cfg[2]), .cfg_monitor_freq_range(cfg[4:3]),
    .cfg_pll_enable(cfg[5]), .cfg_reset_delay_select(cfg[6]),
    .cfg_watchdog_halt_reset_opt(cfg[7]), .cfg_watchdog_enable_source(cfg[8]),
    .osc_tick(osc_tick), .cpu_tick(cpu_tick), .halt_exec(halt_exec), .halt_exit(halt_exit),
    .pin_pc1_in(pin_pc1_in), .pin_pd1_in(pin_pd1_in), .pin_pd345_in(pin_pd345_in),
    .pin_pbc_in(pin_pbc_in), .timer_out(timer_out), .lin_out(lin_out),
    .timer_capture_in_two(cap), .timer_in(timer_in), .lin_in(lin_in),
    .pin_pd345_out(pd_out), .pin_pbc_out(pbc_out), .lin_serial_unit_en(lin_en),
    .clk_src_safe(safe), .pll_enable(pll_en), .pll_in_range(pll_rng), .cpu_hold(hold),
    .chip_reset_req(rst_req), .watchdog_en(wdg_en), .irq(irq));
  always #2.5 pclk = ~pclk;
  // oscillator ticks, one every per cycles, none when per is 0
  always @(posedge pclk) begin
    cpu_tick <= slow ? !cpu_tick : 1'b1;
    if (per != 0 && tcnt >= per - 1) begin
      osc_tick <= 1'b1;
      tcnt     <= 0;
    end else begin
      osc_tick <= 1'b0;
      tcnt     <= tcnt + 1;
    end
  end
  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge pclk);
      end
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k == 20) begin
        n_errors = n_errors + 1;
        end_of_test;
      end
    end
  endtask
  task hold_w(input integer dl);
    begin
      n = 0;
      #1;
      while (hold !== 1'b0 && n < 9000) begin
        @(posedge pclk);
        #1;
        n = n + 1;
      end
      if (n == 9000) begin
        n_errors = n_errors + 1;
        end_of_test;
      end
      chk("hold_len", 1, n >= dl && n <= dl + 6);
    end
  endtask
  task run(input integer idx);
    begin
      c = tbl[idx];
      @(posedge pclk);
      cfg <= c; per <= pertbl[idx]; presetn <= 1'b0;
      slow <= (idx == 1);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      hold_w((c[6] ? 4096 : 256) * (idx == 1 ? 2 : 1));
      apb(8'h00, 1'b0, 32'h0); chk("opts", c, q[8:0]);
      @(posedge pclk);
      cfg <= ~c; pin_pc1_in <= 1'b1; pin_pd1_in <= 1'b0; pin_pd345_in <= 3'h5;
      pin_pbc_in <= 3'h2; timer_out <= 3'h3; lin_out <= 3'h6;
      repeat (3) @(posedge pclk); #1;
      chk("cap", !c[0], cap);
      chk("route", c[1] ? {1'b0, 12'hbd8} : {1'b1, 12'h573},
        {lin_en, timer_in, lin_in, pd_out, pbc_out});
      apb(8'h00, 1'b0, 32'h0); chk("opts_fix", c, q[8:0]);
      chk("wdg_en0", c[8], wdg_en);
      apb(8'h04, 1'b1, 32'h1); apb(8'h0c, 1'b1, 32'h4); apb(8'h08, 1'b1, 32'hf);
      repeat (2) @(posedge pclk); #1;
      chk("wdg_en", 1, wdg_en);
      chk("pll", {c[5], idx == 2}, {pll_en, pll_rng});
      chk("safe", 0, safe);
      @(posedge pclk) halt_exec <= 1'b1;
      @(posedge pclk) halt_exec <= 1'b0;
      #1 chk("rst_req", c[7], rst_req);
      repeat (2) @(posedge pclk); #1;
      chk("irq", c[7], irq);
      apb(8'h08, 1'b1, 32'h4);
      repeat (2) @(posedge pclk); #1;
      chk("irq_clr", 0, irq);
      @(posedge pclk) halt_exit <= 1'b1;
      @(posedge pclk) halt_exit <= 1'b0;
      hold_w((c[6] ? 4096 : 256) * (idx == 1 ? 2 : 1));
      @(posedge pclk) per <= 0;
      repeat (500) @(posedge pclk); #1;
      chk("safe_set", 1, safe);
      chk("irq_mask", 0, irq);
      apb(8'h08, 1'b0, 32'h0); chk("stat0", 1, q[0]);
      apb(8'h40, 1'b0, 32'h0); chk("unm_err", 1, e);
      chk("unm_data", 0, q);
    end
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    cfg = 0; osc_tick = 0; halt_exec = 0; halt_exit = 0; pin_pc1_in = 0; pin_pd1_in = 0;
    pin_pd345_in = 0; pin_pbc_in = 0; timer_out = 0; lin_out = 0; per = 0; tcnt = 0;
    n_errors = 0; n_checks = 0;
    cpu_tick = 1; slow = 0;
    tbl[0] = 9'h1a4; tbl[1] = 9'h10f; tbl[2] = 9'h0f6; tbl[3] = 9'h01d;
    pertbl[0] = 20; pertbl[1] = 33; pertbl[2] = 66; pertbl[3] = 200;
    for (i = 0; i < 4; i = i + 1) begin
      run(i);
      $display("test %0d done", i);
    end
    end_of_test;
  end
endmodule // moc_top_tb
